// File: gdm_engine.sv
// two-channel memory-to-memory dma engine with descriptor fetch
// assumes an apb master for registers and one shared memory master port
//
// Notes on behaviour
// - two independent channels move memory to memory once started.
// - addresses increment, decrement or stay; units are byte, half-word or word.
// - completion shows in a pollable status and on an interrupt output.
// - direct mode goes idle after the count; software reprograms for more.
// - descriptor fetch only while run bit 3 is one and bit 2 zero.
// - direct software transfer starts with control bits 16 and 0 set.
// - software request zero, source field 01 or 10: i/o paced transfer.
// - software can restart a stopped direct mode channel by rewriting its controls.
// - writing 0x04 to the pointer resets it and disables descriptors.
// - writing the pointer with run set fetches four descriptor words.
// - fetched words load next pointer, source, destination, control, count.
// - top fourteen command bits go to count, the rest to control.
// - every completed descriptor fetch overwrites the control register.
// - i/o paced direct mode depends on enable, field 3:2 and the synchronised i/o request pin.
// - in descriptor mode enable and source field come from the list.
// - sequential flag one: next descriptor at current plus 16 bytes.
// - pointer bit 0 resets the channel, clears status; reads 0x05.
// - count at zero ends descriptor; without the sequential flag pointer takes the stored next pointer.
// - an error clears run in descriptor mode and stops the channel until software restarts.
`timescale 1ns/100ps
`default_nettype none
module gdm_engine
	import gdm_pkg::*;
#(
	parameter int NCH = GDM_CH_NUM
)
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb register port
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	// i/o request pins, one per channel
	input wire logic [NCH-1:0] ioReq,
	// memory master port
	output logic busReq,
	input wire logic busGnt,
	output logic memValid,
	output gdm_mem_cmd_t memCmd,
	input wire logic memReady,
	input wire logic [31:0] memRdata,
	input wire logic memErr,
	// completion interrupt
	output logic dmaIrq
);

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] stepAddr(input logic [31:0] a, input logic [1:0] sz,
		input logic fix, input logic dec);
		logic [31:0] inc;
		inc = 32'h0000_0001 << sz;
		if (fix)
			return a;
		else if (dec)
			return a - inc;
		else
			return a + inc;
	endfunction

	function automatic logic [31:0] descBase(input logic [31:0] p);
		return {p[31:4], 4'h0};
	endfunction

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [31:0] ctl_q [NCH];
	logic [31:0] srcb_q [NCH];
	logic [31:0] dstb_q [NCH];
	logic [31:0] csrc_q [NCH];
	logic [31:0] cdst_q [NCH];
	logic [31:0] dadr_q [NCH];
	logic [31:0] nextDadr_q [NCH];
	logic [GDM_TCNT_W-1:0] tcnt_q [NCH];
	logic [GDM_TCNT_W-1:0] ctcnt_q [NCH];
	logic [NCH-1:0] fetchPend_q;
	logic [NCH-1:0] done_q;
	logic [NCH-1:0] err_q;
	logic [NCH-1:0] want;
	logic [NCH-1:0] ioLevel_q;
	logic [NCH-1:0] ioSync_q [GDM_SYNC_STAGES];
	gdm_eng_state_t state_q;
	logic chSel_q;
	logic lastCh_q;
	logic pick;
	logic [1:0] fetchIdx_q;
	logic cmdValid_q;
	gdm_mem_cmd_t cmd_q;
	logic cmdDone;
	logic cmdErr;
	logic [31:0] cmdRdata;
	logic apbWr;
	logic apbSetup;
	logic regHit;
	logic regCh;
	logic [2:0] regIdx;
	logic statHit;

	// ----------------------------------------
	// i/o request synchroniser
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int s = 0; s < GDM_SYNC_STAGES; s++)
				ioSync_q[s] <= '0;
			ioLevel_q <= '0;
		end
		else
		begin
			ioSync_q[0] <= ioReq;
			for (int s = 1; s < GDM_SYNC_STAGES; s++)
				ioSync_q[s] <= ioSync_q[s-1];
			for (int c = 0; c < NCH; c++)
				if (ioSync_q[1][c] == ioSync_q[2][c])
					ioLevel_q[c] <= ioSync_q[2][c];
		end
	end

	// ----------------------------------------
	// channel eligibility
	// ----------------------------------------
	always_comb
	begin
		for (int c = 0; c < NCH; c++)
		begin
			logic [1:0] ms;
			logic trig;
			logic modeOk;
			ms = ctl_q[c][GDM_CTL_MS_LO +: 2];
			// the software request bit still triggers in i/o paced mode
			trig = ctl_q[c][GDM_CTL_SWREQ]
				|| ((ms == GDM_MS_IO_A || ms == GDM_MS_IO_B) && ioLevel_q[c]);
			// list control words carry no software request; enable and field suffice
			if (!dadr_q[c][GDM_DADR_NONDSC] && ms == 2'h0)
				trig = 1'b1;
			modeOk = dadr_q[c][GDM_DADR_NONDSC] || dadr_q[c][GDM_DADR_RUN];
			want[c] = fetchPend_q[c]
				|| (ctl_q[c][GDM_CTL_EN] && trig && modeOk && ctcnt_q[c] != '0);
		end
		// round robin keeps one busy channel from locking out the other
		pick = (want[0] && want[1]) ? ~lastCh_q : want[1];
	end

	// ----------------------------------------
	// engine sequencer
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			state_q <= ENG_IDLE;
			chSel_q <= 1'b0;
			lastCh_q <= 1'b0;
			fetchIdx_q <= 2'h0;
			cmdValid_q <= 1'b0;
			cmd_q <= '0;
		end
		else
		begin
			cmdValid_q <= 1'b0;
			unique case (state_q)
				ENG_IDLE:
					if (|want)
					begin
						chSel_q <= pick;
						lastCh_q <= pick;
						cmdValid_q <= 1'b1;
						if (fetchPend_q[pick])
						begin
							state_q <= ENG_FETCH;
							fetchIdx_q <= 2'h0;
							cmd_q <= '{write: 1'b0, size: 2'h2,
								addr: descBase(dadr_q[pick]), wdata: '0};
						end
						else
						begin
							state_q <= ENG_RD;
							cmd_q <= '{write: 1'b0, size: ctl_q[pick][GDM_CTL_TWS_LO +: 2],
								addr: csrc_q[pick], wdata: '0};
						end
					end
				ENG_FETCH:
					if (cmdDone)
					begin
						if (cmdErr || fetchIdx_q == 2'h3 || !fetchPend_q[chSel_q])
							state_q <= ENG_IDLE;
						else
						begin
							fetchIdx_q <= fetchIdx_q + 2'h1;
							cmdValid_q <= 1'b1;
							cmd_q.addr <= cmd_q.addr + 32'h0000_0004;
						end
					end
				ENG_RD:
					if (cmdDone)
					begin
						if (cmdErr)
							state_q <= ENG_IDLE;
						else
						begin
							state_q <= ENG_WR;
							cmdValid_q <= 1'b1;
							cmd_q <= '{write: 1'b1, size: ctl_q[chSel_q][GDM_CTL_TWS_LO +: 2],
								addr: cdst_q[chSel_q], wdata: cmdRdata};
						end
					end
				ENG_WR:
					if (cmdDone)
						state_q <= ENG_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	assign apbSetup = psel && !penable;
	assign apbWr = psel && penable && pwrite;
	assign regCh = paddr[5];
	assign regIdx = paddr[4:2];
	assign statHit = paddr == GDM_STAT_OFF;
	assign regHit = paddr[11:6] == 6'h00 && paddr[1:0] == 2'h0;
	assign pready = 1'b1;

	// ----------------------------------------
	// channel registers
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			for (int c = 0; c < NCH; c++)
			begin
				ctl_q[c] <= GDM_REG_RESET;
				srcb_q[c] <= GDM_REG_RESET;
				dstb_q[c] <= GDM_REG_RESET;
				csrc_q[c] <= GDM_REG_RESET;
				cdst_q[c] <= GDM_REG_RESET;
				dadr_q[c] <= GDM_DADR_RESET;
				nextDadr_q[c] <= GDM_REG_RESET;
				tcnt_q[c] <= '0;
				ctcnt_q[c] <= '0;
			end
			fetchPend_q <= '0;
			done_q <= '0;
			err_q <= '0;
		end
		else
		begin
			// status clear first so a same-cycle completion still sets
			if (apbWr && statHit)
			begin
				done_q <= done_q & ~pwdata[NCH-1:0];
				err_q <= err_q & ~pwdata[NCH+1:NCH];
			end

			// results of the engine's memory words
			if (cmdDone && cmdErr && state_q != ENG_IDLE)
			begin
				err_q[chSel_q] <= 1'b1;
				fetchPend_q[chSel_q] <= 1'b0;
				ctl_q[chSel_q][GDM_CTL_EN] <= 1'b0;
				if (!dadr_q[chSel_q][GDM_DADR_NONDSC])
					dadr_q[chSel_q][GDM_DADR_RUN] <= 1'b0;
			end
			else if (cmdDone && state_q == ENG_FETCH && fetchPend_q[chSel_q])
			begin
				unique case (fetchIdx_q)
					2'h0: nextDadr_q[chSel_q] <= cmdRdata;
					2'h1:
					begin
						srcb_q[chSel_q] <= cmdRdata;
						csrc_q[chSel_q] <= cmdRdata;
					end
					2'h2:
					begin
						dstb_q[chSel_q] <= cmdRdata;
						cdst_q[chSel_q] <= cmdRdata;
					end
					2'h3:
					begin
						tcnt_q[chSel_q] <= cmdRdata[31:GDM_CMD_CTL_W];
						ctcnt_q[chSel_q] <= cmdRdata[31:GDM_CMD_CTL_W];
						ctl_q[chSel_q] <= {14'h0000, cmdRdata[GDM_CMD_CTL_W-1:0]};
						fetchPend_q[chSel_q] <= 1'b0;
					end
				endcase
			end
			else if (cmdDone && state_q == ENG_WR)
			begin
				csrc_q[chSel_q] <= stepAddr(csrc_q[chSel_q], ctl_q[chSel_q][GDM_CTL_TWS_LO +: 2],
					ctl_q[chSel_q][GDM_CTL_SAFIX], ctl_q[chSel_q][GDM_CTL_SADIR]);
				cdst_q[chSel_q] <= stepAddr(cdst_q[chSel_q], ctl_q[chSel_q][GDM_CTL_TWS_LO +: 2],
					ctl_q[chSel_q][GDM_CTL_DAFIX], ctl_q[chSel_q][GDM_CTL_DADIR]);
				ctcnt_q[chSel_q] <= ctcnt_q[chSel_q] - GDM_TCNT_W'(1);
				if (ctcnt_q[chSel_q] == GDM_TCNT_W'(1))
				begin
					done_q[chSel_q] <= 1'b1;
					ctl_q[chSel_q][GDM_CTL_EN] <= 1'b0;
					if (!dadr_q[chSel_q][GDM_DADR_NONDSC])
					begin
						// sequential lists step on in memory, others follow the link
						if (dadr_q[chSel_q][GDM_DADR_SEQUENTIAL_NEXT_FLAG])
							dadr_q[chSel_q] <= {dadr_q[chSel_q][31:4] + 28'h1,
								nextDadr_q[chSel_q][3:0]};
						else
							dadr_q[chSel_q] <= nextDadr_q[chSel_q];
						fetchPend_q[chSel_q] <= nextDadr_q[chSel_q][GDM_DADR_RUN]
							&& !nextDadr_q[chSel_q][GDM_DADR_NONDSC];
					end
				end
			end

			// software writes win over the engine for stored values
			if (apbWr && regHit && !statHit)
				unique case (regIdx)
					GDM_REG_CTL:
					begin
						ctl_q[regCh] <= pwdata;
						if (pwdata[GDM_CTL_EN])
						begin
							// enabling reloads the working copies for a fresh run
							csrc_q[regCh] <= srcb_q[regCh];
							cdst_q[regCh] <= dstb_q[regCh];
							ctcnt_q[regCh] <= tcnt_q[regCh];
						end
					end
					GDM_REG_SRCB: srcb_q[regCh] <= pwdata;
					GDM_REG_DSTB: dstb_q[regCh] <= pwdata;
					GDM_REG_TCNT: tcnt_q[regCh] <= pwdata[GDM_TCNT_W-1:0];
					GDM_REG_DADR:
						if (pwdata[GDM_DADR_RST])
						begin
							dadr_q[regCh] <= GDM_DADR_CHRST;
							fetchPend_q[regCh] <= 1'b0;
							done_q[regCh] <= 1'b0;
							err_q[regCh] <= 1'b0;
							ctl_q[regCh][GDM_CTL_EN] <= 1'b0;
						end
						else if (pwdata == GDM_DADR_RESET)
						begin
							dadr_q[regCh] <= GDM_DADR_RESET;
							fetchPend_q[regCh] <= 1'b0;
						end
						else
						begin
							// address and flags arrive in one write
							dadr_q[regCh] <= pwdata;
							fetchPend_q[regCh] <= pwdata[GDM_DADR_RUN]
								&& !pwdata[GDM_DADR_NONDSC];
						end
					default: ;
				endcase
		end
	end

	// ----------------------------------------
	// apb read data, captured in the setup cycle
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			prdata <= GDM_REG_RESET;
			pslverr <= 1'b0;
		end
		else if (apbSetup)
		begin
			pslverr <= !regHit && !statHit;
			prdata <= GDM_REG_RESET;
			if (statHit)
				prdata <= {28'h0000000, err_q, done_q};
			else if (regHit)
				unique case (regIdx)
					GDM_REG_CTL: prdata <= ctl_q[regCh];
					GDM_REG_SRCB: prdata <= srcb_q[regCh];
					GDM_REG_DSTB: prdata <= dstb_q[regCh];
					GDM_REG_TCNT: prdata <= {18'h00000, tcnt_q[regCh]};
					GDM_REG_CSRC: prdata <= csrc_q[regCh];
					GDM_REG_CDST: prdata <= cdst_q[regCh];
					GDM_REG_CTCNT: prdata <= {18'h00000, ctcnt_q[regCh]};
					GDM_REG_DADR: prdata <= dadr_q[regCh];
				endcase
		end
	end

	// ----------------------------------------
	// completion interrupt
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			dmaIrq <= 1'b0;
		else
			dmaIrq <= (done_q[0] && ctl_q[0][GDM_CTL_DINTS])
				|| (done_q[1] && ctl_q[1][GDM_CTL_DINTS]);
	end

	// ----------------------------------------
	// memory master port
	// ----------------------------------------
	gdm_mem_port memPort (
		.core_clk(core_clk),
		.rst(rst),
		.cmdValid(cmdValid_q),
		.cmd(cmd_q),
		.cmdDone(cmdDone),
		.cmdRdata(cmdRdata),
		.cmdErr(cmdErr),
		.busReq(busReq),
		.busGnt(busGnt),
		.memValid(memValid),
		.memCmd(memCmd),
		.memReady(memReady),
		.memRdata(memRdata),
		.memErr(memErr)
	);

endmodule
`default_nettype wire

// File: gdm_mem_model.sv
// arbiter and 256-byte memory answering the engine's master port
// assumes one word command at a time; slow stretches grant and ready
`timescale 1ns/100ps
`default_nettype none
module gdm_mem_model
	import gdm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// engine side
	input wire logic busReq,
	output logic busGnt,
	input wire logic memValid,
	input wire gdm_mem_cmd_t memCmd,
	output logic memReady,
	output logic [31:0] memRdata,
	output logic memErr,
	// pacing
	input wire logic slow
);
	logic [31:0] memArr [0:63];
	logic [2:0] waitQ;
	logic take;
	assign take = memValid && !memReady && (!slow || waitQ >= 3'h5);
	always_ff @(posedge core_clk or posedge rst)
		if (rst || !busReq)
			waitQ <= 3'h0;
		else if (waitQ != 3'h7)
			waitQ <= waitQ + 3'h1;
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
			busGnt <= 1'b0;
		else
			busGnt <= busReq && (busGnt || !slow || waitQ >= 3'h2);
	// outside a handshake the data lines toggle so stale values never look valid
	always_ff @(posedge core_clk or posedge rst)
		if (rst)
		begin
			memReady <= 1'b0;
			memRdata <= 32'h0;
			memErr <= 1'b0;
		end
		else
		begin
			memReady <= take;
			memRdata <= take ? memArr[memCmd.addr[7:2]] : ~memRdata;
			memErr <= take ? memCmd.addr[31:28] == 4'hf : ~memErr;
		end
	always @(posedge core_clk)
		if (take && memCmd.write)
			for (int b = 0; b < 4; b++)
				if (memCmd.size == 2'h2 || b[1:0] == memCmd.addr[1:0]
					|| (memCmd.size == 2'h1 && b[1] == memCmd.addr[1]))
					memArr[memCmd.addr[7:2]][8*b +: 8] <= memCmd.wdata[8*b +: 8];
endmodule
`default_nettype wire

// File: gdm_mem_port.sv
// single-word memory master port of the dma engine
// assumes an arbiter grant that stays high until busReq falls
`timescale 1ns/100ps
`default_nettype none
module gdm_mem_port
	import gdm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// engine side
	input wire logic cmdValid,
	input wire gdm_mem_cmd_t cmd,
	output logic cmdDone,
	output logic [31:0] cmdRdata,
	output logic cmdErr,
	// arbiter and memory side
	output logic busReq,
	input wire logic busGnt,
	output logic memValid,
	output gdm_mem_cmd_t memCmd,
	input wire logic memReady,
	input wire logic [31:0] memRdata,
	input wire logic memErr
);

	gdm_port_state_t state_q;

	// ----------------------------------------
	// request, grant, one word, release
	// ----------------------------------------
	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			state_q <= PORT_IDLE;
		else
			unique case (state_q)
				PORT_IDLE: if (cmdValid) state_q <= PORT_REQ;
				PORT_REQ: if (busGnt) state_q <= PORT_XFER;
				PORT_XFER: if (memReady) state_q <= PORT_IDLE;
				default: state_q <= PORT_IDLE;
			endcase
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
			memCmd <= '0;
		else if (state_q == PORT_IDLE && cmdValid)
			memCmd <= cmd;
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			cmdDone <= 1'b0;
			cmdErr <= 1'b0;
			cmdRdata <= GDM_REG_RESET;
		end
		else
		begin
			cmdDone <= state_q == PORT_XFER && memReady;
			cmdErr <= state_q == PORT_XFER && memReady && memErr;
			if (state_q == PORT_XFER && memReady)
				cmdRdata <= memRdata;
		end
	end

	// bus is given back after every word so the other master is not starved
	assign busReq = state_q != PORT_IDLE;
	assign memValid = state_q == PORT_XFER;

endmodule
`default_nettype wire

// File: gdm_pkg.sv
// constants, field positions and carrier types of the two-channel dma engine
// assumes a 32-bit apb register port and a 32-bit word memory master port
package gdm_pkg;

	// ----------------------------------------
	// channel count and widths
	// ----------------------------------------
	localparam int GDM_CH_NUM = 2;
	localparam int GDM_TCNT_W = 14;

	// ----------------------------------------
	// register word indices inside one channel window, channel stride and status offset
	// ----------------------------------------
	localparam logic [2:0] GDM_REG_CTL = 3'h0;
	localparam logic [2:0] GDM_REG_SRCB = 3'h1;
	localparam logic [2:0] GDM_REG_DSTB = 3'h2;
	localparam logic [2:0] GDM_REG_TCNT = 3'h3;
	localparam logic [2:0] GDM_REG_CSRC = 3'h4;
	localparam logic [2:0] GDM_REG_CDST = 3'h5;
	localparam logic [2:0] GDM_REG_CTCNT = 3'h6;
	localparam logic [2:0] GDM_REG_DADR = 3'h7;
	localparam logic [11:0] GDM_CH_STRIDE = 12'h020;
	localparam logic [11:0] GDM_STAT_OFF = 12'h040;

	// ----------------------------------------
	// channel control fields
	// ----------------------------------------
	localparam int GDM_CTL_EN = 0;
	localparam int GDM_CTL_MS_LO = 2;
	localparam int GDM_CTL_DADIR = 4;
	localparam int GDM_CTL_SADIR = 5;
	localparam int GDM_CTL_DAFIX = 6;
	localparam int GDM_CTL_SAFIX = 7;
	localparam int GDM_CTL_DINTS = 10;
	localparam int GDM_CTL_TWS_LO = 12;
	localparam int GDM_CTL_SWREQ = 16;
	localparam int GDM_CMD_CTL_W = 18;
	localparam logic [1:0] GDM_MS_IO_A = 2'h1;
	localparam logic [1:0] GDM_MS_IO_B = 2'h2;

	// ----------------------------------------
	// descriptor pointer fields and values
	// ----------------------------------------
	localparam int GDM_DADR_RST = 0;
	localparam int GDM_DADR_SEQUENTIAL_NEXT_FLAG = 1;
	localparam int GDM_DADR_NONDSC = 2;
	localparam int GDM_DADR_RUN = 3;
	localparam logic [31:0] GDM_DADR_RESET = 32'h0000_0004;
	localparam logic [31:0] GDM_DADR_CHRST = 32'h0000_0005;
	localparam logic [31:0] GDM_DESC_STEP = 32'h0000_0010;

	// ----------------------------------------
	// reset values and synchroniser depth
	// ----------------------------------------
	localparam logic [31:0] GDM_REG_RESET = 32'h0000_0000;
	localparam int GDM_SYNC_STAGES = 3;

	// ----------------------------------------
	// carriers
	// ----------------------------------------
	typedef struct packed {
		logic write;
		logic [1:0] size;
		logic [31:0] addr;
		logic [31:0] wdata;
	} gdm_mem_cmd_t;

	typedef enum logic [1:0] {
		ENG_IDLE = 2'b00,
		ENG_FETCH = 2'b01,
		ENG_RD = 2'b10,
		ENG_WR = 2'b11
	} gdm_eng_state_t;

	typedef enum logic [1:0] {
		PORT_IDLE = 2'b00,
		PORT_REQ = 2'b01,
		PORT_XFER = 2'b10
	} gdm_port_state_t;

endpackage

// File: gdm_props.sv
// assertions on the engine's apb and memory master ports
// assumes binding onto gdm_engine; only its ports are seen
`timescale 1ns/100ps
`default_nettype none
module gdm_props
	import gdm_pkg::*;
(
	// clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	// memory
	input wire logic busReq,
	input wire logic busGnt,
	input wire logic memValid,
	input wire gdm_mem_cmd_t memCmd,
	input wire logic memReady
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	logic wrAcc;
	logic rdSet;
	assign wrAcc = psel && penable && pwrite;
	assign rdSet = psel && !penable && !pwrite && paddr == 12'h01c;
	// ----
	// register side
	// ----
	a_fetch_starts: assert property (
		wrAcc && paddr == 12'h01c && pwdata[3:2] == 2'h2 && !pwdata[0] |-> ##[1:40] busReq)
		else $error("no fetch after pointer write");
	a_fetch_off: assert property (
		wrAcc && paddr == 12'h01c && pwdata[2] && !busReq |=> !busReq [*8])
		else $error("fetch while direct mode set");
	a_sw_start: assert property (
		wrAcc && paddr == 12'h000 && pwdata[16] && pwdata[0] |-> ##[1:40] busReq)
		else $error("software request did not start");
	a_ptr_clear: assert property (
		wrAcc && paddr == 12'h01c && pwdata == GDM_DADR_RESET ##1 rdSet
		|=> prdata == GDM_DADR_RESET)
		else $error("pointer not cleared");
	a_chan_reset: assert property (
		wrAcc && paddr == 12'h01c && pwdata == 32'h1 ##1 rdSet |=> prdata == GDM_DADR_CHRST)
		else $error("channel reset value wrong");
	// ----
	// memory side
	// ----
	a_cmd_stable: assert property (
		memValid && !memReady |=> memValid && $stable(memCmd))
		else $error("memory command moved before ready");
	a_grant_first: assert property (
		$rose(memValid) |-> $past(busGnt) && busReq)
		else $error("transfer without grant");
	a_word_ends: assert property (
		memValid && memReady |=> !memValid && !busReq)
		else $error("bus held after ready");
	a_size_legal: assert property (
		memValid |-> memCmd.size != 2'h3)
		else $error("illegal unit size");
endmodule
bind gdm_engine gdm_props u_props (
	.core_clk(core_clk),
	.rst(rst),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.busReq(busReq),
	.busGnt(busGnt),
	.memValid(memValid),
	.memCmd(memCmd),
	.memReady(memReady)
);
`default_nettype wire

// File: tb_top.sv
// self-checking bench: apb master, memory model, direct, descriptor and i/o runs
// assumes memory words 0..7 hold the source pattern and 0x80.. the descriptors
`timescale 1ns/100ps
`default_nettype none
module tb_top
	import gdm_pkg::*;
;
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] wr;
		logic [31:0] rstVal;
		logic [31:0] after;
		logic err;
	} gdm_row_t;
	logic core_clk, rst, psel, penable, pwrite, pready, pslverr, errv;
	logic busReq, busGnt, memValid, memReady, memErr, dmaIrq, slow;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdv, memRdata;
	logic [1:0] ioReq;
	gdm_mem_cmd_t memCmd;
	gdm_mem_cmd_t logQ [$];
	int nMismatch = 0;
	int checksDone = 0;
	int n, k;
	gdm_row_t rows [10] = '{
		'{12'h004, 32'h10, 32'h0, 32'h10, 1'b0},
		'{12'h008, 32'h40, 32'h0, 32'h40, 1'b0},
		'{12'h00c, 32'hffff_ffff, 32'h0, 32'h3fff, 1'b0},
		'{12'h010, 32'h1234_5678, 32'h0, 32'h0, 1'b0},
		'{12'h018, 32'h1234_5678, 32'h0, 32'h0, 1'b0},
		'{12'h01c, 32'h4, 32'h4, 32'h4, 1'b0},
		'{12'h020, 32'h400, 32'h0, 32'h400, 1'b0},
		'{12'h028, 32'h80, 32'h0, 32'h80, 1'b0},
		'{12'h040, 32'h0, 32'h0, 32'h0, 1'b0},
		'{12'h044, 32'h1234_5678, 32'h0, 32'h0, 1'b1}};
	// next pointer, source, destination, command at 0x80, 0x90, 0xa0
	logic [31:0] descW [12] = '{32'ha, 32'h0, 32'hc0, 32'h0004_2001,
		32'h4, 32'h10, 32'hd0, 32'h0008_2401, 32'h4, 32'hf000_0000, 32'he8, 32'h0004_2001};
	gdm_engine dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .ioReq(ioReq), .busReq(busReq), .busGnt(busGnt),
		.memValid(memValid), .memCmd(memCmd), .memReady(memReady), .memRdata(memRdata),
		.memErr(memErr), .dmaIrq(dmaIrq));
	gdm_mem_model mem (.core_clk(core_clk), .rst(rst), .busReq(busReq), .busGnt(busGnt),
		.memValid(memValid), .memCmd(memCmd), .memReady(memReady), .memRdata(memRdata),
		.memErr(memErr), .slow(slow));
	initial
	begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial
	begin
		repeat (50000) @(posedge core_clk);
		nMismatch++;
		endSim();
	end
	always @(posedge core_clk)
		if (memValid && memReady)
			logQ.push_back(memCmd);
	// ----
	// tasks
	// ----
	task automatic endSim;
		$display("checks %0d mismatches %0d", checksDone, nMismatch);
		if (nMismatch == 0 && checksDone > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checksDone++;
		if (seen !== exp)
		begin
			nMismatch++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// rel low keeps psel up so the next setup follows at once
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
		input bit rel = 1'b1);
		int t;
		t = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge core_clk);
			t++;
		end
		while (pready !== 1'b1 && t < 20);
		rdv = prdata;
		errv = pslverr;
		if (pready !== 1'b1)
		begin
			nMismatch++;
			endSim();
		end
		if (rel)
		begin
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge core_clk);
		end
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rc(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rdv, e);
	endtask
	task automatic waitMem(input int i, input logic [31:0] v);
		int t;
		t = 0;
		while (mem.memArr[i] !== v && t < 400)
		begin
			@(posedge core_clk);
			t++;
		end
		chk(mem.memArr[i], v);
		if (t >= 400)
			endSim();
		repeat (4) @(posedge core_clk);
	endtask
	// ----
	// sequence
	// ----
	initial
	begin
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		ioReq = 2'h0;
		slow = 1'b0;
		for (int i = 0; i < 64; i++)
			mem.memArr[i] = (i < 8) ? 32'hc0de_0000 + i : 32'h0;
		for (int i = 0; i < 12; i++)
			mem.memArr[32+i] = descW[i];
		repeat (10) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		foreach (rows[i])
		begin
			rc(rows[i].addr, rows[i].rstVal);
			apb(1'b1, rows[i].addr, rows[i].wr, 1'b0);
			rc(rows[i].addr, rows[i].after);
			chk({31'h0, errv}, {31'h0, rows[i].err});
		end
		wr(12'h004, 32'h0);
		wr(12'h008, 32'h40);
		wr(12'h00c, 32'h4);
		wr(12'h000, 32'h0001_2401);
		waitMem(19, 32'hc0de_0003);
		chk(mem.memArr[16], 32'hc0de_0000);
		rc(12'h040, 32'h1);
		chk({31'h0, dmaIrq}, 32'h1);
		rc(12'h010, 32'h10);
		n = logQ.size();
		repeat (20) @(posedge core_clk);
		chk(32'(logQ.size()), 32'(n));
		wr(12'h040, 32'h1);
		repeat (3) @(posedge core_clk);
		chk({31'h0, dmaIrq}, 32'h0);
		// restart counting down, with the far side stalling
		slow <= 1'b1;
		wr(12'h004, 32'hc);
		wr(12'h008, 32'h7c);
		wr(12'h000, 32'h0001_2431);
		waitMem(28, 32'hc0de_0000);
		chk(mem.memArr[31], 32'hc0de_0003);
		slow <= 1'b0;
		wr(12'h040, 32'h1);
		logQ.delete();
		wr(12'h01c, 32'h8a);
		waitMem(53, 32'hc0de_0005);
		chk(mem.memArr[48], 32'hc0de_0000);
		for (int i = 0; i < 4; i++)
			chk({logQ[i].write, logQ[i].addr[30:0]}, 32'h80 + 32'(4 * i));
		chk(logQ[6].addr, 32'h90);
		rc(12'h000, 32'h2400);
		rc(12'h00c, 32'h2);
		rc(12'h004, 32'h10);
		rc(12'h008, 32'hd0);
		wr(12'h01c, 32'h8c);
		n = logQ.size();
		repeat (20) @(posedge core_clk);
		chk(32'(logQ.size()), 32'(n));
		apb(1'b1, 12'h01c, GDM_DADR_RESET, 1'b0);
		rc(12'h01c, 32'h4);
		apb(1'b1, 12'h01c, 32'h1, 1'b0);
		rc(12'h01c, 32'h5);
		rc(12'h040, 32'h0);
		// a source in the faulting region ends the list at once
		wr(12'h01c, 32'ha8);
		k = 0;
		do
		begin
			apb(1'b0, 12'h040, 32'h0);
			k++;
		end
		while (rdv[2] !== 1'b1 && k < 50);
		chk(rdv & 32'h4, 32'h4);
		apb(1'b0, 12'h01c, 32'h0);
		chk(rdv & 32'h8, 32'h0);
		chk(mem.memArr[58], 32'h0);
		for (int c = 0; c < 2; c++)
		begin
			wr(12'h024, 32'h0);
			wr(12'h028, 32'hf0 + 32'(8 * c));
			wr(12'h02c, 32'h2);
			wr(12'h020, 32'h2001 | 32'((c + 1) << 2));
			n = logQ.size();
			repeat (20) @(posedge core_clk);
			chk(32'(logQ.size()), 32'(n));
			ioReq <= 2'h2;
			waitMem(61 + 2 * c, 32'hc0de_0001);
			ioReq <= 2'h0;
		end
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		rc(12'h01c, GDM_DADR_RESET);
		endSim();
	end
endmodule
`default_nettype wire
